// ===== src/pns_pkg.sv
// constants and types shared by the pipelined static memory port
package pns_pkg;
  // ------------------------------------------------------------------
  // geometry defaults (512K words, four lanes with parity)
  // ------------------------------------------------------------------
  localparam int ADDR_W = 19;
  localparam int LANES = 4;
  localparam int PARITY = 1;
  localparam int BYTE_W = 8;
  localparam int MAX_LANES = 4;
  localparam int MAX_ADDR_W = 20;

  // ------------------------------------------------------------------
  // burst and pipeline figures
  // ------------------------------------------------------------------
  localparam int BURST_W = 2;
  localparam int DATA_LAT_CYC = 2;
  localparam logic ORDER_LINEAR = 1'b0;
  localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic RST_BIT = 1'b0;
  localparam logic RST_INACTIVE_N = 1'b1;
  localparam logic RST_ORDER = 1'b1;
  localparam logic [BURST_W-1:0] RST_CNT = 2'h0;
  localparam logic [MAX_ADDR_W-1:0] RST_ADDR = 20'h00000;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {BURST_IDLE, BURST_READ, BURST_WRITE} pns_burst_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [MAX_ADDR_W-1:0] addr;
    logic [MAX_LANES-1:0] lane_en;
  } pns_op_t;

  localparam pns_op_t RST_OP = '{valid: 1'b0, write: 1'b0, addr: 20'h00000, lane_en: 4'h0};
endpackage : pns_pkg

// ===== src/pns_array.sv
// storage array with per-lane write enables and asynchronous read
`timescale 1ns/1ps
module pns_array #(
  parameter int ADDR_W = pns_pkg::ADDR_W,
  parameter int LANES = pns_pkg::LANES,
  parameter int LANE_W = pns_pkg::BYTE_W + pns_pkg::PARITY
) (
  input wire logic clk,
  input wire logic write_en,
  input wire logic [LANES-1:0] lane_en,
  input wire logic [ADDR_W-1:0] write_addr,
  input wire logic [LANES*LANE_W-1:0] write_data,
  input wire logic [ADDR_W-1:0] read_addr,
  output logic [LANES*LANE_W-1:0] read_data
);
  // ------------------------------------------------------------------
  // one memory per lane so each enable touches only its own bits
  // ------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      logic [LANE_W-1:0] mem [0:(2**ADDR_W)-1];
      // lane write, gated by its own enable
      always_ff @(posedge clk) begin
        if (write_en && lane_en[g]) begin
          mem[write_addr] <= write_data[g*LANE_W +: LANE_W];
        end
      end
      assign read_data[g*LANE_W +: LANE_W] = mem[read_addr];
    end
  endgenerate
endmodule : pns_array

// ===== src/pns_port.sv
// pipelined no-turnaround static memory port, device side
`timescale 1ns/1ps
module pns_port #(
  parameter int ADDR_W = pns_pkg::ADDR_W,
  parameter int LANES = pns_pkg::LANES,
  parameter int PARITY = pns_pkg::PARITY,
  localparam int LANE_W = pns_pkg::BYTE_W + PARITY,
  localparam int DATA_W = LANES * LANE_W
) (
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic SELECT_FIRST_N,
  input wire logic SELECT_SECOND_N,
  input wire logic SELECT_THIRD,
  input wire logic ADDR_LOAD_OR_ADVANCE_N,
  input wire logic WRITE_N,
  input wire logic [LANES-1:0] LANE_WRITE_EN_N,
  input wire logic CLOCK_EN_N,
  input wire logic BURST_ORDER_SELECT,
  input wire logic OUTPUT_EN_N,
  input wire logic SNOOZE_REQUEST,
  input wire logic [DATA_W-1:0] DATA_IN,
  output logic [DATA_W-1:0] DATA_OUT,
  output logic DATA_OE
);
  // ------------------------------------------------------------------
  // parameter checks
  // ------------------------------------------------------------------
  // parity only with two or four lanes
  generate
    if (!((LANES == 4) || (LANES == 2 && PARITY == 1)) || PARITY > 1 ||
        ADDR_W < pns_pkg::BURST_W || ADDR_W > pns_pkg::MAX_ADDR_W) begin : g_bad_param
      $error("pns_port: unsupported width or lane configuration");
    end
  endgenerate

  // the pipe is built with exactly two stages from address to data
  generate
    if (pns_pkg::DATA_LAT_CYC != 2) begin : g_bad_latency
      $error("pns_port: data latency does not match the two-stage pipe");
    end
  endgenerate

  // ------------------------------------------------------------------
  // synchronisers for the asynchronous pins
  // ------------------------------------------------------------------
  logic oe_n_meta;
  logic oe_n_sync;
  logic snooze_meta;
  logic snooze_sync;
  logic order_meta;
  logic order_sync;

  // two flops each, only the second one is read
  // the order pin is static, so its lag only matters after reset
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      oe_n_meta <= pns_pkg::RST_INACTIVE_N;
      oe_n_sync <= pns_pkg::RST_INACTIVE_N;
      snooze_meta <= pns_pkg::RST_BIT;
      snooze_sync <= pns_pkg::RST_BIT;
      order_meta <= pns_pkg::RST_ORDER;
      order_sync <= pns_pkg::RST_ORDER;
    end else begin
      oe_n_meta <= OUTPUT_EN_N;
      oe_n_sync <= oe_n_meta;
      snooze_meta <= SNOOZE_REQUEST;
      snooze_sync <= snooze_meta;
      order_meta <= BURST_ORDER_SELECT;
      order_sync <= order_meta;
    end
  end

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  pns_pkg::pns_burst_t burst_state;
  logic [pns_pkg::MAX_ADDR_W-1:0] base_addr;
  logic [pns_pkg::BURST_W-1:0] burst_cnt;
  pns_pkg::pns_op_t stage1;
  pns_pkg::pns_op_t stage2;
  logic out_valid;
  logic [DATA_W-1:0] read_data;

  // ------------------------------------------------------------------
  // decode of the captured control inputs
  // ------------------------------------------------------------------
  // clock enable and snooze freeze the pipe
  // snooze stops the pipe and turns the drivers off, array contents kept
  wire run = !CLOCK_EN_N && !snooze_sync;
  wire selected = !SELECT_FIRST_N && !SELECT_SECOND_N && SELECT_THIRD;
  wire load = !ADDR_LOAD_OR_ADVANCE_N;
  wire [pns_pkg::MAX_ADDR_W-1:0] ext_addr = pns_pkg::MAX_ADDR_W'(ADDR);
  wire [pns_pkg::MAX_LANES-1:0] lane_en = pns_pkg::MAX_LANES'(~LANE_WRITE_EN_N);

  wire [pns_pkg::BURST_W-1:0] next_cnt = burst_cnt + pns_pkg::BURST_STEP;
  // low bits only, so the group wraps
  wire [pns_pkg::BURST_W-1:0] low_linear = base_addr[pns_pkg::BURST_W-1:0] + next_cnt;
  wire [pns_pkg::BURST_W-1:0] low_inter = base_addr[pns_pkg::BURST_W-1:0] ^ next_cnt;
  // low picks linear, high or open interleaved
  wire [pns_pkg::BURST_W-1:0] low_sel =
    (order_sync == pns_pkg::ORDER_LINEAR) ? low_linear : low_inter;
  // burst address from base and order
  wire [pns_pkg::MAX_ADDR_W-1:0] adv_addr =
    {base_addr[pns_pkg::MAX_ADDR_W-1:pns_pkg::BURST_W], low_sel};

  // selects looked at only on a load
  wire load_valid = selected;
  // advance keeps the loaded cycle type
  wire adv_valid = burst_state != pns_pkg::BURST_IDLE;
  wire adv_write = burst_state == pns_pkg::BURST_WRITE;

  // cycle type fixed only at a load
  wire [1:0] load_kind = !load_valid ? 2'h0 : (WRITE_N ? 2'h1 : 2'h2);
  wire pns_pkg::pns_burst_t load_state =
    (load_kind == 2'h0) ? pns_pkg::BURST_IDLE :
    (load_kind == 2'h1) ? pns_pkg::BURST_READ : pns_pkg::BURST_WRITE;

  // a load every cycle simply restarts the burst
  wire pns_pkg::pns_op_t next_op = load ?
    '{valid: load_valid, write: !WRITE_N, addr: ext_addr, lane_en: lane_en} :
    '{valid: adv_valid, write: adv_write, addr: adv_addr, lane_en: lane_en};

  // a load restarts the burst from the fresh base
  wire pns_pkg::pns_burst_t next_state = load ? load_state : burst_state;
  wire [pns_pkg::MAX_ADDR_W-1:0] next_base = load ? ext_addr : base_addr;
  wire [pns_pkg::BURST_W-1:0] next_burst_cnt = load ? pns_pkg::RST_CNT : next_cnt;

  // read result leaves two edges after its address
  wire read_now = stage2.valid && !stage2.write;
  wire next_out_valid = run ? read_now : out_valid;
  // drivers on only for read data with enable active
  wire next_oe = next_out_valid && !oe_n_sync && !snooze_sync;

  // write commits with data caught two edges after address
  wire array_we = run && stage2.valid && stage2.write;

  // ------------------------------------------------------------------
  // address, burst and command pipeline
  // ------------------------------------------------------------------
  // all synchronous inputs caught on the rising edge
  // without run every stage keeps its value
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      burst_state <= pns_pkg::BURST_IDLE;
      base_addr <= pns_pkg::RST_ADDR;
      burst_cnt <= pns_pkg::RST_CNT;
      stage1 <= pns_pkg::RST_OP;
      stage2 <= pns_pkg::RST_OP;
    end else if (run) begin
      burst_state <= next_state;
      base_addr <= next_base;
      burst_cnt <= next_burst_cnt;
      // lane enables travel with their address
      stage1 <= next_op;
      stage2 <= stage1;
    end
  end

  // ------------------------------------------------------------------
  // output data register and driver enable
  // ------------------------------------------------------------------
  // one operation per stage, so no turnaround gap
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      DATA_OUT <= '0;
      out_valid <= pns_pkg::RST_BIT;
      DATA_OE <= pns_pkg::RST_BIT;
    end else begin
      // the output holds the last read value between beats
      if (run && read_now) begin
        DATA_OUT <= read_data;
      end
      out_valid <= next_out_valid;
      DATA_OE <= next_oe;
    end
  end

  // ------------------------------------------------------------------
  // storage
  // ------------------------------------------------------------------
  // per-lane enables go straight to per-lane memories
  // write data taken from the bus at the stage two edge
  pns_array #(
    .ADDR_W(ADDR_W),
    .LANES(LANES),
    .LANE_W(LANE_W)
  ) u_array (
    .clk(CLK_SYS),
    .write_en(array_we),
    .lane_en(stage2.lane_en[LANES-1:0]),
    .write_addr(stage2.addr[ADDR_W-1:0]),
    .write_data(DATA_IN),
    .read_addr(stage2.addr[ADDR_W-1:0]),
    .read_data(read_data)
  );
endmodule : pns_port

// ===== verif/pns_port_asserts.sv
// pin-level checks of the static memory port
`timescale 1ns/1ps
module pns_port_asserts #(
  parameter int LANES = 4,
  parameter int PARITY = 1
) (
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic SELECT_FIRST_N,
  input wire logic SELECT_SECOND_N,
  input wire logic SELECT_THIRD,
  input wire logic ADDR_LOAD_OR_ADVANCE_N,
  input wire logic WRITE_N,
  input wire logic CLOCK_EN_N,
  input wire logic OUTPUT_EN_N,
  input wire logic SNOOZE_REQUEST,
  input wire logic [LANES*(pns_pkg::BYTE_W+PARITY)-1:0] DATA_OUT,
  input wire logic DATA_OE
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);
  // ----
  // decoded cycles
  // ----
  wire logic run = !CLOCK_EN_N && !SNOOZE_REQUEST && !OUTPUT_EN_N;
  wire logic sel_on = !SELECT_FIRST_N && !SELECT_SECOND_N && SELECT_THIRD;
  wire logic load = run && !ADDR_LOAD_OR_ADVANCE_N;
  wire logic rd_ld = load && sel_on && WRITE_N;
  property p_out_run; !$stable(DATA_OUT) |-> !$past(CLOCK_EN_N); endproperty
  a_out_run: assert property (p_out_run) else $error("frozen data moved");
  property p_freeze; CLOCK_EN_N |=> $stable(DATA_OE); endproperty
  a_freeze: assert property (p_freeze) else $error("frozen enable moved");
  property p_rd_lat; run[*3] ##1 rd_ld ##1 run[*2] |=> DATA_OE; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read beat late");
  property p_adv;
    run[*3] ##1 rd_ld ##1 (run && ADDR_LOAD_OR_ADVANCE_N) ##1 run[*2] |-> DATA_OE ##1 DATA_OE;
  endproperty
  a_adv: assert property (p_adv) else $error("advance lost read");
  property p_no_rd; run[*3] ##1 (load && !(sel_on && WRITE_N)) ##1 run[*2] |=> !DATA_OE; endproperty
  a_no_rd: assert property (p_no_rd) else $error("spurious read beat");
  property p_turn;
    run[*3] ##1 (load && sel_on && !WRITE_N) ##1 rd_ld ##1 run[*2] |-> !DATA_OE ##1 DATA_OE;
  endproperty
  a_turn: assert property (p_turn) else $error("write to read gap");
  property p_oe_off; OUTPUT_EN_N[*4] |-> !DATA_OE; endproperty
  a_oe_off: assert property (p_oe_off) else $error("driving while disabled");
  property p_snooze; SNOOZE_REQUEST[*4] |-> !DATA_OE; endproperty
  a_snooze: assert property (p_snooze) else $error("driving in standby");
endmodule : pns_port_asserts
bind pns_port pns_port_asserts #(.LANES(LANES), .PARITY(PARITY)) i_pns_port_asserts (
  .CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .SELECT_FIRST_N(SELECT_FIRST_N),
  .SELECT_SECOND_N(SELECT_SECOND_N), .SELECT_THIRD(SELECT_THIRD), .WRITE_N(WRITE_N),
  .ADDR_LOAD_OR_ADVANCE_N(ADDR_LOAD_OR_ADVANCE_N), .CLOCK_EN_N(CLOCK_EN_N),
  .OUTPUT_EN_N(OUTPUT_EN_N), .SNOOZE_REQUEST(SNOOZE_REQUEST), .DATA_OUT(DATA_OUT),
  .DATA_OE(DATA_OE));

// ===== verif/pns_ctrl_model.sv
// controller model: late write data on the data lines
`timescale 1ns/1ps
module pns_ctrl_model (
  input wire logic clk,
  input wire logic clk_en_n,
  input wire logic wr,
  input wire logic [35:0] wdata,
  output logic [35:0] data_in
);
  logic p_wr = 1'b0;
  logic [35:0] p_d = 36'h0;
  initial data_in = 36'h0;
  // data two run edges behind, toggled when idle
  always @(posedge clk) begin
    if (!clk_en_n) begin
      p_wr <= wr;
      p_d <= wdata;
      data_in <= p_wr ? p_d : ~data_in;
    end
  end
endmodule : pns_ctrl_model

// ===== verif/pns_port_test.sv
// self-checking bench for the static memory port
`timescale 1ns/1ps
module pns_port_test;
  logic clk = 1'b0, rst_n = 1'b0, ld_n = 1'b0, wr_n = 1'b1, ce_n = 1'b0, order = 1'b1;
  logic oe_n = 1'b0, snooze = 1'b0, wr = 1'b0, oe_on = 1'b1, doe, run_e;
  logic [2:0] sel = 3'h0;
  logic [5:0] addr = 6'h00;
  logic [3:0] ln_n = 4'hf;
  logic [35:0] wdata = 36'h0, seq = 36'h1, din, dout, mem [64], exp_q [$];
  int n_errors = 0, n_checks = 0;
  always #2 clk = ~clk;
  pns_port #(.ADDR_W(6)) i_pns_port (.CLK_SYS(clk), .RESET_N(rst_n), .ADDR(addr),
    .SELECT_FIRST_N(sel[2]), .SELECT_SECOND_N(sel[1]), .SELECT_THIRD(sel[0]),
    .ADDR_LOAD_OR_ADVANCE_N(ld_n), .WRITE_N(wr_n), .LANE_WRITE_EN_N(ln_n), .CLOCK_EN_N(ce_n),
    .BURST_ORDER_SELECT(order), .OUTPUT_EN_N(oe_n), .SNOOZE_REQUEST(snooze), .DATA_IN(din),
    .DATA_OUT(dout), .DATA_OE(doe));
  pns_ctrl_model i_pns_ctrl_model (.clk(clk), .clk_en_n(ce_n), .wr(wr), .wdata(wdata),
    .data_in(din));
  task automatic chk(input logic [35:0] seen, input logic [35:0] want);
    n_checks++;
    if (seen !== want) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, want);
    end
  endtask : chk
  // one bus cycle; an advance scrambles the inputs it must ignore
  task automatic beat(input logic adv, input logic w, input logic [5:0] a, input logic [3:0] l,
                      input logic [2:0] s);
    @(posedge clk);
    seq = seq * 36'hd + 36'h9e3779b97;
    ce_n <= 1'b0;
    ld_n <= adv;
    // direction and selects inverted on advance
    wr_n <= adv ? w : !w;
    sel <= adv ? ~s : s;
    addr <= adv ? ~a : a;
    ln_n <= l;
    wdata <= seq;
    wr <= w && s == 3'h1;
    if (w && s == 3'h1) for (int g = 0; g < 4; g++) if (!l[g]) mem[a][g*9+:9] = seq[g*9+:9];
    if (!w && s == 3'h1 && oe_on) exp_q.push_back(mem[a]);
  endtask : beat
  task automatic idle(input int n);
    repeat (n) beat(1'b0, 1'b0, 6'h00, 4'hf, 3'h0);
  endtask : idle
  task automatic stall(input int n);
    @(posedge clk);
    ce_n <= 1'b1;
    repeat (n - 1) @(posedge clk);
  endtask : stall
  task automatic drain;
    idle(4);
    chk(36'(exp_q.size()), 36'h0);
  endtask : drain
  // each read beat on a run edge against the reference copy
  always @(posedge clk) begin
    run_e = !ce_n && !snooze;
    #1;
    if (run_e && doe === 1'b1) begin
      if (exp_q.size() == 0) chk(36'h1, 36'h0);
      else chk(dout, exp_q.pop_front());
    end
  end
  // single lanes, then writes and reads back to back
  task automatic t_rw;
    beat(1'b0, 1'b1, 6'h05, 4'h0, 3'h1);
    for (int g = 0; g < 4; g++) beat(1'b0, 1'b1, 6'h05, ~(4'h1 << g), 3'h1);
    for (int i = 0; i < 4; i++) begin
      beat(1'b0, 1'b1, 6'h10 + 6'(i), 4'h0, 3'h1);
      beat(1'b0, 1'b0, 6'h10 + 6'(i), 4'hf, 3'h1);
      beat(1'b0, 1'b0, 6'h05, 4'hf, 3'h1);
    end
    drain;
  endtask : t_rw
  // five beats from base 0x0d wrap to the base
  task automatic t_burst(input logic o);
    logic [5:0] b;
    @(posedge clk);
    order <= o;
    idle(3);
    for (int k = 0; k < 10; k++) begin
      b = o == pns_pkg::ORDER_LINEAR ? {4'h3, 2'h1 + 2'(k % 5)} : {4'h3, 2'h1 ^ 2'(k % 5)};
      beat(k % 5 > 0, k < 5, b, 4'h0, 3'h1);
    end
    drain;
  endtask : t_burst
  // any inactive select makes a deselect
  task automatic t_desel;
    for (int s = 0; s < 8; s++) beat(1'b0, s[2], 6'h05, 4'h0, 3'(s));
    // advances after a deselect stay deselects
    beat(1'b1, 1'b1, 6'h05, 4'h0, 3'h0);
    beat(1'b1, 1'b0, 6'h05, 4'h0, 3'h0);
    beat(1'b0, 1'b0, 6'h05, 4'hf, 3'h1);
    drain;
  endtask : t_desel
  // frozen edges stretch reads and hold write data
  task automatic t_stall;
    beat(1'b0, 1'b1, 6'h12, 4'h0, 3'h1);
    stall(2);
    beat(1'b0, 1'b0, 6'h05, 4'hf, 3'h1);
    stall(3);
    beat(1'b0, 1'b0, 6'h12, 4'hf, 3'h1);
    drain;
  endtask : t_stall
  // drivers off while disabled or in standby, contents kept
  task automatic t_quiet(input logic z);
    @(posedge clk);
    oe_n <= !z;
    snooze <= z;
    oe_on = 1'b0;
    idle(4);
    beat(1'b0, 1'b0, 6'h05, 4'hf, 3'h1);
    idle(3);
    #1 chk(36'(doe), 36'h0);
    @(posedge clk);
    oe_n <= 1'b0;
    snooze <= 1'b0;
    idle(4);
    oe_on = 1'b1;
    beat(1'b0, 1'b0, 6'h12, 4'hf, 3'h1);
    drain;
  endtask : t_quiet
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (4) @(posedge clk);
    chk(dout, 36'h0);
    rst_n <= 1'b1;
    idle(3);
    t_rw;
    t_burst(1'b1);
    t_burst(1'b0);
    t_desel;
    t_stall;
    t_quiet(1'b0);
    t_quiet(1'b1);
    end_of_test;
  end
endmodule : pns_port_test
